/* File: hdl/ect_pkg.sv */
//==========================================================================
// Purpose: shared constants and types of the edge capture timer
// Assumes: 32-bit Avalon-MM register bus, byte addresses, one word a reg
// Notes:   all registers are 8 bits wide in the low byte lane
//==========================================================================
package ect_pkg;

   //=======================================================================
   // register byte offsets
   localparam logic [4:0] ECT_OFS_MODE = 5'h00;
   localparam logic [4:0] ECT_OFS_FCAP = 5'h04;
   localparam logic [4:0] ECT_OFS_RCAP = 5'h08;
   localparam logic [4:0] ECT_OFS_CLK_STOP = 5'h0C;
   localparam logic [4:0] ECT_OFS_PORT = 5'h10;
   localparam logic [4:0] ECT_OFS_IRQ = 5'h14;

   //=======================================================================
   // field positions outside the mode register
   localparam int unsigned ECT_STBY_BIT = 3;
   localparam int unsigned ECT_PIN_SEL_BIT = 0;
   localparam int unsigned ECT_NF_SEL_BIT = 1;
   localparam int unsigned ECT_IRQ_FLAG_BIT = 0;
   localparam int unsigned ECT_IRQ_EN_BIT = 1;

   //=======================================================================
   // values after reset, and the counter maximum
   localparam logic [7:0] ECT_MODE_RST = 8'h00;
   localparam logic [7:0] ECT_CLK_STOP_RST = 8'hFF;
   localparam logic [7:0] ECT_CNT_RST = 8'h00;
   localparam logic [7:0] ECT_CAP_RST = 8'h00;
   localparam logic [7:0] ECT_CNT_MAX = 8'hFF;

   //=======================================================================
   // prescaler taps and counts
   localparam int unsigned ECT_PRESC_W = 6;
   localparam int unsigned ECT_DIV64_BIT = 5;
   localparam int unsigned ECT_DIV32_BIT = 4;
   localparam int unsigned ECT_DIV2_BIT = 0;
   localparam int unsigned ECT_WDIV_W = 2;
   localparam int unsigned ECT_FILT_STAGES = 5;

   //=======================================================================
   // count clock choices
   typedef enum logic [1:0] {
      ECT_CK_DIV64 = 2'b00,
      ECT_CK_DIV32 = 2'b01,
      ECT_CK_DIV2 = 2'b10,
      ECT_CK_WDIV4 = 2'b11
   } ect_clk_sel_t;

   // counter clear choices: bit 1 rising, bit 0 falling
   typedef enum logic [1:0] {
      ECT_CLR_NONE = 2'b00,
      ECT_CLR_FALL = 2'b01,
      ECT_CLR_RISE = 2'b10,
      ECT_CLR_BOTH = 2'b11
   } ect_clr_sel_t;

   // mode control register layout, bit 7 first
   typedef struct packed {
      logic overflow_high_flag;
      logic overflow_low_flag;
      logic overflow_irq_enable;
      logic capture_irq_edge_select;
      ect_clr_sel_t clr_sel;
      ect_clk_sel_t clk_sel;
   } ect_mode_t;

endpackage : ect_pkg

/* File: hdl/ect_noise_filter.sv */
//==========================================================================
// Purpose: five-latch all-agree noise filter for the capture input
// Assumes: sample_en_i is a one-cycle enable of the chosen sampling rate
// Notes:   ready_o rises once five low samples have been seen
//==========================================================================
`timescale 1ns/100ps
module ect_noise_filter
   import ect_pkg::*;
#(
   parameter int unsigned STAGES = ECT_FILT_STAGES
)
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // sample stream
   input wire logic sample_en_i,
   input wire logic din_i,
   // filtered level
   output logic dout_o,
   output logic ready_o
);

   logic [STAGES-1:0] shift_q;
   logic all_hi;
   logic all_lo;

   // agreement of every latch
   assign all_hi = &shift_q;
   assign all_lo = ~|shift_q;

   //=======================================================================
   // latch chain, shifted on the sampling enable only
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         shift_q <= '1;
      else if (sample_en_i)
         shift_q <= {shift_q[STAGES-2:0], din_i};
   end

   // output moves only on full match
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         dout_o <= 1'b1;
      else if (all_hi)
         dout_o <= 1'b1;
      else if (all_lo)
         dout_o <= 1'b0;
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ready_o <= 1'b0;
      else if (all_lo)
         ready_o <= 1'b1;
   end

   chk_filter_hold: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (!all_hi && !all_lo) |=> $stable(dout_o))
      else $error("filter output moved without full match");

endmodule : ect_noise_filter

/* File: hdl/ect_top.sv */
//==========================================================================
// Purpose: 8-bit up counter with edge capture, overflow level detect
// Assumes: capture pin and watch clock are synchronous to ref_clk_i
// Notes:   waitrequest holds every access for exactly one cycle
//==========================================================================
// What this block does
// - overflow requests an interrupt only while the overflow enable is 1
// - edge select bit 0 picks rising, 1 picks falling for capture request
// - clear field: 00 never, 01 falling, 10 rising, 11 both edges clear
// - clock field: 00 div 64, 01 div 32, 10 div 2, 11 watch div 4
// - standby bit resets to 1; writing 0 halts the whole timer
// - five latches in series; output changes only when all agree
// - filter samples on system clock, or count clock rising when selected
// - after reset the filter is ready once low is sampled five times
// - with filtering, edges arrive five sampling cycles late
// - pin select 1 means capture timer, 0 means interval timer
// - reset zeroes mode, port, irq regs, counter, captures; counting starts at div 64
// - rising edge copies count to rising capture, falling to falling
// - chosen edge sets the request flag; enable passes it to the cpu
// - capture-mode overflow sets high or low flag by the input level
// - overflow flag set with overflow enable sets the request flag
// - interval mode overflow from all ones to zero sets the low flag
// - changing filter select may produce a spurious edge, kept as is
// - overflow flags clear by reading 1 then writing 0; 1 does nothing
// - the counter itself cannot be read or written by software
// - counter steps on falling count clock, including switch-over falls
//==========================================================================
//
// Implementation choices: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module ect_top
   import ect_pkg::*;
(
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic nrst_i,
   // avalon-mm slave
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // pins
   input wire logic cap_pin_i,
   input wire logic wclk_i,
   // interrupt controller
   output logic irq_set_o,
   output logic irq_req_o
);

   //=======================================================================
   // declarations
   ect_mode_t mode_q;
   logic [7:0] clk_stop_q;
   logic pin_sel_q;
   logic nf_sel_q;
   logic irq_flag_q;
   logic irq_en_q;
   logic arm_hi_q;
   logic arm_lo_q;
   logic ack_q;
   logic [ECT_PRESC_W-1:0] presc_q;
   logic [ECT_WDIV_W-1:0] wdiv_q;
   logic wclk_prev_q;
   logic sel_prev_q;
   logic sel_lvl;
   logic [7:0] cnt_q;
   logic [7:0] fall_cap_q;
   logic [7:0] rise_cap_q;
   logic filt;
   logic filt_rdy;
   logic filt_prev_q;
   logic rdy_prev_q;
   logic run;
   logic inc;
   logic sel_rise;
   logic sample_en;
   logic cap_in;
   logic rise_evt;
   logic fall_evt;
   logic clr_evt;
   logic ovf_evt;
   logic cap_mode;
   logic set_evt;
   logic wr_acc;
   logic rd_acc;
   logic wr_lo;
   logic wr_mode;
   logic [7:0] rd_mux;

   //=======================================================================
   // bus decode
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
   assign wr_acc = avs_write_i & ack_q;
   assign rd_acc = avs_read_i & ack_q;
   assign wr_lo = wr_acc & avs_byteenable_i[0];
   // the mode register is frozen while the timer is in standby
   assign wr_mode = wr_lo & run & (avs_address_i == ECT_OFS_MODE);

   // one wait cycle, then the access completes
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         ack_q <= 1'b0;
      else
         ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
   end

   always_comb
   begin
      case (avs_address_i)
         ECT_OFS_MODE: rd_mux = mode_q;
         ECT_OFS_FCAP: rd_mux = fall_cap_q;
         ECT_OFS_RCAP: rd_mux = rise_cap_q;
         ECT_OFS_CLK_STOP: rd_mux = clk_stop_q;
         ECT_OFS_PORT: rd_mux = {6'h00, nf_sel_q, pin_sel_q};
         ECT_OFS_IRQ: rd_mux = {6'h00, irq_en_q, irq_flag_q};
         default: rd_mux = 8'h00;
      endcase
   end

   // read data latched in the wait cycle, stands through the answer
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (avs_read_i && !ack_q)
         avs_readdata_o <= {24'h00_0000, rd_mux};
   end

   //=======================================================================
   // control registers
   // standby control resets to running
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         clk_stop_q <= ECT_CLK_STOP_RST;
      else if (wr_lo && avs_address_i == ECT_OFS_CLK_STOP)
         clk_stop_q <= avs_writedata_i[7:0];
   end

   assign run = clk_stop_q[ECT_STBY_BIT];

   // pin function and filter select
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         pin_sel_q <= 1'b0;
         nf_sel_q <= 1'b0;
      end
      else if (wr_lo && avs_address_i == ECT_OFS_PORT)
      begin
         pin_sel_q <= avs_writedata_i[ECT_PIN_SEL_BIT];
         nf_sel_q <= avs_writedata_i[ECT_NF_SEL_BIT];
      end
   end

   // pin select chooses capture or interval mode
   assign cap_mode = pin_sel_q;

   // writable mode fields reset to zero
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mode_q.overflow_irq_enable <= 1'b0;
         mode_q.capture_irq_edge_select <= 1'b0;
         mode_q.clr_sel <= ECT_CLR_NONE;
         mode_q.clk_sel <= ECT_CK_DIV64;
      end
      else if (wr_mode)
      begin
         mode_q.overflow_irq_enable <= avs_writedata_i[5];
         mode_q.capture_irq_edge_select <= avs_writedata_i[4];
         mode_q.clr_sel <= ect_clr_sel_t'(avs_writedata_i[3:2]);
         mode_q.clk_sel <= ect_clk_sel_t'(avs_writedata_i[1:0]);
      end
   end

   // a read that sees a flag at 1 arms its clear
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         arm_hi_q <= 1'b0;
         arm_lo_q <= 1'b0;
      end
      else if (rd_acc && avs_address_i == ECT_OFS_MODE)
      begin
         arm_hi_q <= avs_readdata_o[7];
         arm_lo_q <= avs_readdata_o[6];
      end
      else if (wr_mode)
      begin
         arm_hi_q <= 1'b0;
         arm_lo_q <= 1'b0;
      end
   end

   // flag picked by the filtered level; set wins over clear
   // interval mode always reports through the low flag
   // writing 1 never sets, writing 0 clears only when armed
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         mode_q.overflow_high_flag <= 1'b0;
         mode_q.overflow_low_flag <= 1'b0;
      end
      else
      begin
         if (ovf_evt && cap_mode && filt)
            mode_q.overflow_high_flag <= 1'b1;
         else if (wr_mode && arm_hi_q && !avs_writedata_i[7])
            mode_q.overflow_high_flag <= 1'b0;
         if (ovf_evt && !(cap_mode && filt))
            mode_q.overflow_low_flag <= 1'b1;
         else if (wr_mode && arm_lo_q && !avs_writedata_i[6])
            mode_q.overflow_low_flag <= 1'b0;
      end
   end

   //=======================================================================
   // count clock generation
   // prescaler halts in standby so the counter cannot step
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         presc_q <= '0;
      else if (run)
         presc_q <= presc_q + 1'b1;
   end

   // watch clock divided by four on its rising edges
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wclk_prev_q <= 1'b0;
         wdiv_q <= '0;
      end
      else
      begin
         wclk_prev_q <= wclk_i;
         if (run && wclk_i && !wclk_prev_q)
            wdiv_q <= wdiv_q + 1'b1;
      end
   end

   always_comb
   begin
      case (mode_q.clk_sel)
         ECT_CK_DIV64: sel_lvl = presc_q[ECT_DIV64_BIT];
         ECT_CK_DIV32: sel_lvl = presc_q[ECT_DIV32_BIT];
         ECT_CK_DIV2: sel_lvl = presc_q[ECT_DIV2_BIT];
         ECT_CK_WDIV4: sel_lvl = wdiv_q[ECT_WDIV_W-1];
         default: sel_lvl = 1'b0;
      endcase
   end

   // the previous level follows the mux, so a switch is seen as an edge
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         sel_prev_q <= 1'b0;
      else if (run)
         sel_prev_q <= sel_lvl;
   end

   // falling count clock steps the counter
   assign inc = run & sel_prev_q & ~sel_lvl;
   assign sel_rise = run & ~sel_prev_q & sel_lvl;

   //=======================================================================
   // capture input path
   // unselected pin reads low, so toggling the select can make an edge
   assign cap_in = pin_sel_q & cap_pin_i;

   // sampling on system clock or count clock rising
   // a select change alters sampling and may leave a false edge
   assign sample_en = run & (nf_sel_q ? sel_rise : 1'b1);

   // five latches give the five-sample edge delay
   ect_noise_filter #(
      .STAGES(ECT_FILT_STAGES)
   ) u_filter (
      .ref_clk_i(ref_clk_i),
      .nrst_i(nrst_i),
      .sample_en_i(sample_en),
      .din_i(cap_in),
      .dout_o(filt),
      .ready_o(filt_rdy)
   );

   // edge detector on the filtered level
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         filt_prev_q <= 1'b1;
         rdy_prev_q <= 1'b0;
      end
      else
      begin
         filt_prev_q <= filt;
         rdy_prev_q <= filt_rdy;
      end
   end

   // no edge counts before the filter has initialized
   assign rise_evt = run & rdy_prev_q & filt & ~filt_prev_q;
   assign fall_evt = run & rdy_prev_q & ~filt & filt_prev_q;

   assign clr_evt = (rise_evt & mode_q.clr_sel[1])
                  | (fall_evt & mode_q.clr_sel[0]);
   assign ovf_evt = inc & ~clr_evt & (cnt_q == ECT_CNT_MAX);

   //=======================================================================
   // counter and captures
   // counter starts from zero
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         cnt_q <= ECT_CNT_RST;
      else if (clr_evt)
         cnt_q <= ECT_CNT_RST;
      else if (inc)
         cnt_q <= cnt_q + 8'h01;
   end

   // edge copies the count before any clear
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         rise_cap_q <= ECT_CAP_RST;
         fall_cap_q <= ECT_CAP_RST;
      end
      else
      begin
         if (rise_evt)
            rise_cap_q <= cnt_q;
         if (fall_evt)
            fall_cap_q <= cnt_q;
      end
   end

   //=======================================================================
   // interrupt request
   // edge select; overflow enable
   assign set_evt = (mode_q.capture_irq_edge_select ? fall_evt : rise_evt)
                  | (ovf_evt & mode_q.overflow_irq_enable);

   // request flag: a set in the clearing cycle wins
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         irq_flag_q <= 1'b0;
         irq_en_q <= 1'b0;
      end
      else
      begin
         if (set_evt)
            irq_flag_q <= 1'b1;
         else if (wr_lo && avs_address_i == ECT_OFS_IRQ
                  && !avs_writedata_i[ECT_IRQ_FLAG_BIT])
            irq_flag_q <= 1'b0;
         if (wr_lo && avs_address_i == ECT_OFS_IRQ)
            irq_en_q <= avs_writedata_i[ECT_IRQ_EN_BIT];
      end
   end

   // one pulse for both sources, gated by the enable
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         irq_set_o <= 1'b0;
      else
         irq_set_o <= set_evt & irq_en_q;
   end

   assign irq_req_o = irq_flag_q & irq_en_q;

   //=======================================================================
   // checks
   // no overflow request when disabled
   chk_ovf_irq_gate: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ovf_evt && !mode_q.overflow_irq_enable && !rise_evt && !fall_evt)
      |=> !irq_set_o)
      else $error("overflow request leaked while disabled");

   // rising edge with select 0 sets the flag
   chk_cap_edge_sel: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rise_evt && !mode_q.capture_irq_edge_select) |=> irq_flag_q)
      else $error("rising edge did not set request flag");

   chk_clear_rise: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (rise_evt && mode_q.clr_sel[1]) |=> cnt_q == 8'h00)
      else $error("rising edge did not clear counter");

   // each falling count clock without a clear adds one
   chk_count_step: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (inc && !clr_evt) |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("counter missed a step");

   chk_standby_hold: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (!run ##1 !run) |-> $stable(cnt_q))
      else $error("counter moved in standby");

   // rising capture holds the prior count
   chk_rise_capture: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      rise_evt |=> rise_cap_q == $past(cnt_q))
      else $error("rising capture value wrong");

   // overflow with high input sets the high flag
   chk_ovf_high: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ovf_evt && cap_mode && filt) |=> mode_q.overflow_high_flag)
      else $error("high overflow flag not set");

   // interval overflow sets the low flag and wraps to zero
   chk_ovf_interval: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (ovf_evt && !cap_mode) |=> mode_q.overflow_low_flag && cnt_q == 8'h00)
      else $error("interval overflow not reported");

endmodule : ect_top

/* File: tb/ect_pulse_src.sv */
// Purpose: pulse source model driving the capture pin
// Assumes: levels change right after a rising clock edge
// Notes:   caller picks each hold length in clock cycles
`timescale 1ns/100ps
module ect_pulse_src
(
   // clock
   input wire logic clk_i,
   // capture pin
   output logic pin_o
);
   //======================================================================
   // drive
   initial pin_o = 1'b0;

   // level stands for the whole hold span
   task hold(input logic lvl, input int cyc);
      pin_o <= lvl;
      repeat (cyc) @(posedge clk_i);
   endtask : hold
endmodule : ect_pulse_src

/* File: tb/ect_top_bench.sv */
// Purpose: self-checking bench for the edge capture timer
// Assumes: filter select is 0 except in the last scenario
// Notes:   capture counts are checked within one count of slack
`timescale 1ns/100ps
module ect_top_bench
   import ect_pkg::*;
;
   //======================================================================
   // signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic wait_o;
   logic pin;
   logic wclk = 1'b0;
   logic [3:0] wcnt = 4'h0;
   logic irq_set;
   logic irq_req;
   int err_count = 0;
   int n_checks = 0;
   int n_irq = 0;
   int i;
   logic [7:0] v;
   typedef struct packed {
      logic w;
      logic [4:0] a;
      logic [7:0] d;
      logic [7:0] e;
   } ect_row_t;
   ect_row_t rows[20];

   //======================================================================
   // clock, watch clock, pulse counter
   always #4 clk = ~clk;
   // slow watch clock, one period every 16 system clocks
   always @(posedge clk)
   begin
      wcnt <= wcnt + 4'h1;
      wclk <= wcnt[3];
   end
   always @(posedge clk) if (irq_set === 1'b1) n_irq++;

   ect_top dut (.ref_clk_i(clk), .nrst_i(nrst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
      .avs_byteenable_i(4'h1), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wait_o), .cap_pin_i(pin), .wclk_i(wclk),
      .irq_set_o(irq_set), .irq_req_o(irq_req));
   ect_pulse_src src (.clk_i(clk), .pin_o(pin));

   //======================================================================
   // bus and compare tasks
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask : check

   // one access; request held until waitrequest is seen low
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      adr <= a;
      wdat <= {24'h0000_00, d};
      rd <= ~w;
      wr <= w;
      do @(posedge clk); while (wait_o !== 1'b0);
      v = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
   endtask : bus

   task results;
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results

   //======================================================================
   // watchdog
   initial
   begin
      repeat (20000) @(posedge clk);
      err_count++;
      results();
   end

   //======================================================================
   // main sequence
   initial
   begin
      rows = '{'{1'b0,5'h00,8'h00,8'h00}, '{1'b0,5'h04,8'h00,8'h00},
         '{1'b0,5'h08,8'h00,8'h00}, '{1'b0,5'h0C,8'h00,8'hFF},
         '{1'b0,5'h10,8'h00,8'h00}, '{1'b0,5'h14,8'h00,8'h00},
         '{1'b0,5'h18,8'h00,8'h00}, '{1'b1,5'h18,8'hAA,8'h00},
         '{1'b1,5'h04,8'h55,8'h00}, '{1'b1,5'h00,8'hC1,8'h01},
         '{1'b1,5'h00,8'h02,8'h02}, '{1'b1,5'h00,8'h03,8'h03},
         '{1'b1,5'h00,8'h24,8'h24}, '{1'b1,5'h00,8'h28,8'h28},
         '{1'b1,5'h00,8'h3C,8'h3C}, '{1'b1,5'h00,8'h10,8'h10},
         '{1'b1,5'h14,8'h02,8'h02}, '{1'b1,5'h14,8'h03,8'h02},
         '{1'b1,5'h14,8'h00,8'h00}, '{1'b1,5'h00,8'h00,8'h00}};
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      for (i = 0; i < 20; i++)
      begin
         if (rows[i].w) bus(1'b1, rows[i].a, rows[i].d);
         bus(1'b0, rows[i].a, 8'h00);
         check(v, rows[i].e);
      end
      // interval overflow at div 2, then clear after reading 1
      bus(1'b1, 5'h00, 8'h02);
      repeat (600) @(posedge clk);
      bus(1'b0, 5'h00, 8'h00);
      check(v, 8'h42);
      bus(1'b0, 5'h14, 8'h00);
      check(v, 8'h00);
      bus(1'b1, 5'h00, 8'h02);
      bus(1'b0, 5'h00, 8'h00);
      check(v, 8'h02);
      // capture mode with pin high overflows into the high flag
      src.hold(1'b1, 10);
      bus(1'b1, 5'h10, 8'h01);
      repeat (600) @(posedge clk);
      bus(1'b0, 5'h00, 8'h00);
      check(v, 8'h82);
      // switching the pin in while it is high looks like a rising edge
      bus(1'b0, 5'h14, 8'h00);
      check(v, 8'h01);
      check({7'h00, irq_req}, 8'h00);
      // clear on both edges, rising edge raises the request
      bus(1'b1, 5'h00, 8'h0E);
      bus(1'b1, 5'h14, 8'h02);
      i = n_irq;
      src.hold(1'b0, 200);
      src.hold(1'b1, 100);
      src.hold(1'b0, 30);
      bus(1'b0, 5'h08, 8'h00);
      check({7'h00, v >= 8'h63 && v <= 8'h65}, 8'h01);
      bus(1'b0, 5'h04, 8'h00);
      check({7'h00, v >= 8'h31 && v <= 8'h33}, 8'h01);
      check({7'h00, irq_req}, 8'h01);
      check(8'(n_irq - i), 8'h01);
      bus(1'b0, 5'h14, 8'h00);
      check(v, 8'h03);
      // a three-cycle high pulse is filtered out
      bus(1'b0, 5'h08, 8'h00);
      i = v;
      src.hold(1'b1, 3);
      src.hold(1'b0, 40);
      bus(1'b0, 5'h08, 8'h00);
      check(v, i[7:0]);
      // standby blocks mode writes
      bus(1'b1, 5'h0C, 8'hF7);
      bus(1'b1, 5'h00, 8'h3F);
      bus(1'b0, 5'h00, 8'h00);
      check(v, 8'h0E);
      bus(1'b0, 5'h0C, 8'h00);
      check(v, 8'hF7);
      // reset in mid-run restores defaults
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      bus(1'b0, 5'h0C, 8'h00);
      check(v, 8'hFF);
      bus(1'b0, 5'h00, 8'h00);
      check(v, 8'h00);
      // overflow with its enable raises the shared request
      bus(1'b1, 5'h14, 8'h02);
      bus(1'b1, 5'h00, 8'h22);
      i = n_irq;
      repeat (600) @(posedge clk);
      bus(1'b0, 5'h00, 8'h00);
      check(v, 8'h62);
      bus(1'b0, 5'h14, 8'h00);
      check(v, 8'h03);
      check(8'(n_irq - i), 8'h01);
      // filter on the count clock: a long pulse passes, a short one not
      bus(1'b1, 5'h00, 8'h02);
      bus(1'b1, 5'h10, 8'h03);
      bus(1'b1, 5'h14, 8'h02);
      src.hold(1'b1, 20);
      bus(1'b0, 5'h14, 8'h00);
      check(v, 8'h03);
      src.hold(1'b0, 20);
      bus(1'b1, 5'h14, 8'h02);
      src.hold(1'b1, 6);
      src.hold(1'b0, 20);
      bus(1'b0, 5'h14, 8'h00);
      check(v, 8'h02);
      results();
   end
endmodule : ect_top_bench
